/* pta_pkg.sv */
// Shared constants and types for the program space table access block
package pta_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PWORD_W = 24;
	localparam int DWORD_W = 16;
	localparam int PAGE_W = 8;
	localparam int OFS_W = 16;

	// ----------------------------------------
	// Register offsets on the plain port
	// ----------------------------------------
	localparam logic [3:0] OFS_PAGE = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_REFUSED = 4'h2;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int PAGE_CFG_BIT = 7;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [15:0] REFUSED_RST = 16'h0000;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSE_BIT = 1;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		PTA_OP_READ_LOW = 2'h0,
		PTA_OP_READ_HIGH = 2'h1,
		PTA_OP_WRITE_LOW = 2'h2,
		PTA_OP_WRITE_HIGH = 2'h3
	} pta_op_t;

	// ----------------------------------------
	// Engine states, one-hot
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		PTA_ST_IDLE = 3'b001,
		PTA_ST_READ = 3'b010,
		PTA_ST_DONE = 3'b100
	} pta_state_t;

endpackage

/* pta_pm_model.sv */
// Program memory model that answers one cycle after a read strobe
`timescale 1ns/1ns
`default_nettype none
module pta_pm_model
(
	input wire logic ref_clk,
	input wire logic pm_rd,
	input wire logic pm_wr,
	input wire logic [22:0] pm_addr,
	input wire logic [23:0] pm_wdata,
	input wire logic [2:0] pm_wbe,
	output logic [23:0] pm_rdata
);
	logic [23:0] mem [64]; // Small array on word index bits 5:0
	logic [23:0] q; // Last word fetched
	logic vld; // Fetched word is on the bus
	// Known contents for the bench to mirror
	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = 24'h5a3c96 ^ (24'(i) * 24'h010203);
		q = 24'h0;
		vld = 1'b0;
	end
	// Answer next cycle; lanes written under their enables
	always @(posedge ref_clk)
	begin
		vld <= pm_rd;
		if (pm_rd)
			q <= mem[pm_addr[5:0]];
		for (int b = 0; b < 3; b++)
			if (pm_wr && pm_wbe[b])
				mem[pm_addr[5:0]][b*8 +: 8] <= pm_wdata[b*8 +: 8];
	end
	// Outside the answer cycle the bus shows inverted data, never stale data
	assign pm_rdata = vld ? q : ~q;
endmodule
`default_nettype wire

/* pta_read_mux.sv */
// Read data steering from a 24-bit program word to a 16-bit data word
`timescale 1ns/1ns
`default_nettype none
module pta_read_mux
(
	input wire logic [23:0] pword,
	input wire logic high_op,
	input wire logic byte_mode,
	input wire logic byte_sel,
	output logic [15:0] rdata
);
	// ----------------------------------------
	// Steering
	// ----------------------------------------
	// Phantom byte above bit 23 always reads as zero
	always_comb
	begin
		rdata = 16'h0000;
		if (!high_op)
		begin
			if (!byte_mode)
				rdata = pword[15:0];
			else if (byte_sel)
				rdata = {8'h00, pword[15:8]};
			else
				rdata = {8'h00, pword[7:0]};
		end
		else
		begin
			if (!byte_mode)
				rdata = {8'h00, pword[23:16]};
			else if (byte_sel)
				rdata = 16'h0000;
			else
				rdata = {8'h00, pword[23:16]};
		end
	end
endmodule
`default_nettype wire

/* pta_table_access.sv */
// Table access datapath between CPU table operations and program memory
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Low ops reach word; high ops upper byte
// - Program address advances by two per word
// - Two side-by-side 16-bit spaces, same range
// - Word low read returns bits 15..0
// - Byte low read selects upper or lower byte
// - Word high read zeroes data bits 15..8
// - Byte high read; phantom byte reads zero
// - Page register gives page; bit7 selects config
// - Config space allows reads, refuses writes
// - Byte or word transfers for both pairs
module pta_table_access
(
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// CPU table operation request
	input wire logic op_valid,
	input wire logic [1:0] op_code,
	input wire logic op_byte,
	input wire logic [15:0] op_offset,
	input wire logic [15:0] op_wdata,
	output logic op_done,
	output logic op_refused,
	output logic [15:0] op_rdata,
	// Program memory port, data back one cycle after a read strobe
	output logic pm_rd,
	output logic pm_wr,
	output logic [22:0] pm_addr,
	output logic [23:0] pm_wdata,
	output logic [2:0] pm_wbe,
	input wire logic [23:0] pm_rdata
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Register port state
	logic [7:0] page_ff; // Table page select register
	logic [7:0] nxt_page;
	logic [15:0] refused_ff; // Count of refused writes
	logic [15:0] nxt_refused;
	logic [15:0] reg_rdata_ff;
	logic [15:0] nxt_reg_rdata;

	// Operation engine state
	pta_pkg::pta_state_t state_ff;
	pta_pkg::pta_state_t nxt_state;
	logic high_ff; // Latched operation kind
	logic nxt_high;
	logic byte_ff;
	logic nxt_byte;
	logic bsel_ff;
	logic nxt_bsel;
	logic done_ff;
	logic nxt_done;
	logic refuse_ff;
	logic nxt_refuse;
	logic last_refuse_ff; // Sticky view of the last outcome
	logic nxt_last_refuse;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;

	// Program memory strobes, address and payload
	logic pm_rd_ff;
	logic nxt_pm_rd;
	logic pm_wr_ff;
	logic nxt_pm_wr;
	logic [22:0] pm_addr_ff;
	logic [22:0] nxt_pm_addr;
	logic [23:0] pm_wdata_ff;
	logic [23:0] nxt_pm_wdata;
	logic [2:0] pm_wbe_ff;
	logic [2:0] nxt_pm_wbe;

	// Decode and steering nets
	logic req_high; // Decoded request fields
	logic req_write;
	logic cfg_space;
	logic [15:0] mux_rdata;
	logic [23:0] mrg_word;
	logic [2:0] mrg_be;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	assign req_high = (op_code == pta_pkg::PTA_OP_READ_HIGH) ||
		(op_code == pta_pkg::PTA_OP_WRITE_HIGH);
	// Codes two and three are writes
	assign req_write = (op_code == pta_pkg::PTA_OP_WRITE_LOW) ||
		(op_code == pta_pkg::PTA_OP_WRITE_HIGH);
	// Bit 7 of the page picks configuration space over user space
	assign cfg_space = page_ff[pta_pkg::PAGE_CFG_BIT];

	// ----------------------------------------
	// Data steering
	// ----------------------------------------
	pta_read_mux u_read_mux
	(
		.pword(pm_rdata),
		.high_op(high_ff),
		.byte_mode(byte_ff),
		.byte_sel(bsel_ff),
		.rdata(mux_rdata)
	);

	pta_write_merge u_write_merge
	(
		.wdata(op_wdata),
		.high_op(req_high),
		.byte_mode(op_byte),
		.byte_sel(op_offset[0]),
		.wword(mrg_word),
		.wbe(mrg_be)
	);

	// ----------------------------------------
	// Register port next values
	// ----------------------------------------
	// Reads answer in the next cycle; unmapped offsets read zero
	// Writes to read-only or unmapped offsets fall through untouched
	always_comb
	begin
		nxt_page = page_ff;
		nxt_reg_rdata = 16'h0000;
		if (reg_wr && (reg_addr == pta_pkg::OFS_PAGE))
			nxt_page = reg_wdata[7:0];
		if (reg_rd)
		begin
			unique case (reg_addr)
				pta_pkg::OFS_PAGE: nxt_reg_rdata = {8'h00, page_ff};
				pta_pkg::OFS_STATUS:
				begin
					nxt_reg_rdata[pta_pkg::STAT_BUSY_BIT] = (state_ff != pta_pkg::PTA_ST_IDLE);
					nxt_reg_rdata[pta_pkg::STAT_REFUSE_BIT] = last_refuse_ff;
				end
				pta_pkg::OFS_REFUSED: nxt_reg_rdata = refused_ff;
				default: nxt_reg_rdata = 16'h0000;
			endcase
		end
	end

	// Register port flip-flops
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			page_ff <= pta_pkg::PAGE_RST;
			reg_rdata_ff <= 16'h0000;
		end
		else
		begin
			page_ff <= nxt_page;
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	// ----------------------------------------
	// Operation engine next values
	// ----------------------------------------
	// Writes finish in one cycle; reads spend two cycles in the read state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_high = high_ff;
		nxt_byte = byte_ff;
		nxt_bsel = bsel_ff;
		nxt_done = 1'b0;
		nxt_refuse = 1'b0;
		nxt_last_refuse = last_refuse_ff;
		nxt_refused = refused_ff;
		nxt_rdata = rdata_ff;
		nxt_pm_rd = 1'b0;
		nxt_pm_wr = 1'b0;
		nxt_pm_addr = pm_addr_ff;
		nxt_pm_wdata = pm_wdata_ff;
		nxt_pm_wbe = pm_wbe_ff;
		unique case (state_ff)
			pta_pkg::PTA_ST_IDLE:
			begin
				// Requests are taken only here; a request while busy is dropped
				if (op_valid)
				begin
					// Offset bit 0 is byte select; words step by two
					// The full page, bit 7 included, forms the top of the address
					nxt_pm_addr = {page_ff, op_offset[15:1]};
					nxt_high = req_high;
					nxt_byte = op_byte;
					nxt_bsel = op_offset[0];
					if (!req_write)
					begin
						nxt_pm_rd = 1'b1;
						nxt_state = pta_pkg::PTA_ST_READ;
					end
					else if (cfg_space)
					begin
						// Refused: no memory strobe, read data kept
						nxt_done = 1'b1;
						nxt_refuse = 1'b1;
						nxt_last_refuse = 1'b1;
						nxt_refused = refused_ff + 16'h0001;
						nxt_state = pta_pkg::PTA_ST_DONE;
					end
					else
					begin
						nxt_pm_wr = 1'b1;
						nxt_pm_wdata = mrg_word;
						nxt_pm_wbe = mrg_be;
						nxt_done = 1'b1;
						nxt_last_refuse = 1'b0;
						nxt_state = pta_pkg::PTA_ST_DONE;
					end
				end
			end
			pta_pkg::PTA_ST_READ:
			begin
				// Memory registers the strobe, so its data stand one cycle later
				if (pm_rd_ff)
				begin
					// Strobe cycle: memory still fetching
					nxt_state = pta_pkg::PTA_ST_READ;
				end
				else
				begin
					// Data cycle: steer the fetched word to the operand
					nxt_rdata = mux_rdata;
					nxt_done = 1'b1;
					nxt_last_refuse = 1'b0;
					nxt_state = pta_pkg::PTA_ST_DONE;
				end
			end
			pta_pkg::PTA_ST_DONE:
			begin
				// One idle cycle while done is shown
				// Requests in this cycle are ignored
				nxt_state = pta_pkg::PTA_ST_IDLE;
			end
			default: nxt_state = pta_pkg::PTA_ST_IDLE;
		endcase
	end

	// Engine flip-flops
	// Reset values are constants; no request survives a reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= pta_pkg::PTA_ST_IDLE;
			high_ff <= 1'b0;
			byte_ff <= 1'b0;
			bsel_ff <= 1'b0;
			done_ff <= 1'b0;
			refuse_ff <= 1'b0;
			last_refuse_ff <= 1'b0;
			refused_ff <= pta_pkg::REFUSED_RST;
			rdata_ff <= 16'h0000;
			pm_rd_ff <= 1'b0;
			pm_wr_ff <= 1'b0;
			pm_addr_ff <= 23'h000000;
			pm_wdata_ff <= 24'h000000;
			pm_wbe_ff <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			high_ff <= nxt_high;
			byte_ff <= nxt_byte;
			bsel_ff <= nxt_bsel;
			done_ff <= nxt_done;
			refuse_ff <= nxt_refuse;
			last_refuse_ff <= nxt_last_refuse;
			refused_ff <= nxt_refused;
			rdata_ff <= nxt_rdata;
			pm_rd_ff <= nxt_pm_rd;
			pm_wr_ff <= nxt_pm_wr;
			pm_addr_ff <= nxt_pm_addr;
			pm_wdata_ff <= nxt_pm_wdata;
			pm_wbe_ff <= nxt_pm_wbe;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a flip-flop, never a gate
	assign reg_rdata = reg_rdata_ff;
	assign op_done = done_ff;
	assign op_refused = refuse_ff;
	assign op_rdata = rdata_ff;
	assign pm_rd = pm_rd_ff;
	assign pm_wr = pm_wr_ff;
	assign pm_addr = pm_addr_ff;
	assign pm_wdata = pm_wdata_ff;
	assign pm_wbe = pm_wbe_ff;
endmodule
`default_nettype wire

/* pta_table_access_properties.sv */
// Checker for table operation timing and write steering
`timescale 1ns/1ns
`default_nettype none
module pta_checker
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic [1:0] op_code,
	input wire logic op_byte,
	input wire logic [15:0] op_offset,
	input wire logic [15:0] op_wdata,
	input wire logic op_done,
	input wire logic op_refused,
	input wire logic [15:0] op_rdata,
	input wire logic pm_rd,
	input wire logic pm_wr,
	input wire logic [22:0] pm_addr,
	input wire logic [23:0] pm_wdata,
	input wire logic [2:0] pm_wbe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------
	// Request steps
	// ------
	sequence rd_req; op_valid && !op_code[1]; endsequence
	sequence wr_req; op_valid && op_code[1]; endsequence
	sequence wr_low_word; op_valid && (op_code == 2'h2) && !op_byte; endsequence
	sequence wr_high_word; op_valid && (op_code == 2'h3) && !op_byte; endsequence
	rd_strobe_a: assert property (rd_req |=> pm_rd && !pm_wr)
		else $error("read strobe missing");
	rd_done_a: assert property (rd_req |-> ##[2:3] op_done)
		else $error("read not finished");
	wr_done_a: assert property (wr_req |=> op_done && !pm_rd)
		else $error("write not finished");
	word_addr_a: assert property (op_valid |=> pm_addr[14:0] == $past(op_offset[15:1]))
		else $error("bad word address");
	refuse_a: assert property (op_refused |-> op_done && !pm_wr)
		else $error("refused write reached memory");
	wr_low_a: assert property (wr_low_word |=> !pm_wr ||
		(pm_wbe == 3'h3 && pm_wdata[15:0] == $past(op_wdata)))
		else $error("bad low word write");
	wr_high_a: assert property (wr_high_word |=> !pm_wr ||
		(pm_wbe == 3'h4 && pm_wdata[23:16] == $past(op_wdata[7:0])))
		else $error("bad high word write");
	rdata_hold_a: assert property ($changed(op_rdata) |-> op_done && !op_refused)
		else $error("read result moved");
endmodule
bind pta_table_access pta_checker chk (.ref_clk, .rst_n, .op_valid, .op_code, .op_byte,
	.op_offset, .op_wdata, .op_done, .op_refused, .op_rdata, .pm_rd, .pm_wr, .pm_addr,
	.pm_wdata, .pm_wbe);
`default_nettype wire

/* pta_table_access_tb.sv */
// Self-checking bench for the table access block
`timescale 1ns/1ns
`default_nettype none
module pta_table_access_tb;
	logic ref_clk, rst_n, reg_wr, reg_rd, op_valid, op_byte, op_done, op_refused, pm_rd, pm_wr;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, op_offset, op_wdata, op_rdata, last_rd, o;
	logic [1:0] op_code;
	logic [22:0] pm_addr;
	logic [23:0] pm_wdata, pm_rdata;
	logic [2:0] pm_wbe;
	logic [23:0] shadow [64]; // Expected memory contents
	logic [7:0] pg; // Page last written
	int miscompares, total_checks, nref;
	pta_table_access dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .op_valid, .op_code, .op_byte, .op_offset, .op_wdata, .op_done,
		.op_refused, .op_rdata, .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_wbe, .pm_rdata);
	pta_pm_model pm (.ref_clk, .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_wbe, .pm_rdata);
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Register access; read data stands only in the cycle after the strobe
	task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask
	task automatic setpg(input logic [7:0] p);
		rg(1'b1, pta_pkg::OFS_PAGE, {8'h0, p});
		pg = p;
	endtask
	function automatic logic [15:0] exp_rd(logic [23:0] w, logic h, logic b, logic s);
		if (!h)
			return b ? {8'h0, s ? w[15:8] : w[7:0]} : w[15:0];
		return {8'h0, (b && s) ? 8'h0 : w[23:16]};
	endfunction
	function automatic logic [23:0] exp_wr(logic [23:0] w, logic h, logic b, logic s,
		logic [15:0] d);
		if (h && !(b && s))
			w[23:16] = d[7:0];
		else if (!h && !b)
			w[15:0] = d;
		else if (!h)
			w[{s, 3'h0} +: 8] = d[7:0];
		return w;
	endfunction
	// One table operation, waited for under a bound, then checked
	task automatic op(input logic [1:0] c, input logic b, input logic [15:0] a, d);
		int n;
		logic rf;
		rf = c[1] && pg[7];
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_byte <= b;
		op_offset <= a;
		op_wdata <= d;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		n = 0;
		while (op_done !== 1'b1 && n < 6)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk({15'h0, op_done}, 16'h1);
		chk({15'h0, op_refused}, {15'h0, rf});
		if (c[1])
		begin
			if (!rf)
				shadow[a[6:1]] = exp_wr(shadow[a[6:1]], c[0], b, a[0], d);
			nref += int'(rf);
			chk(op_rdata, last_rd);
		end
		else
		begin
			last_rd = exp_rd(shadow[a[6:1]], c[0], b, a[0]);
			chk(op_rdata, last_rd);
		end
	endtask
	initial
	begin
		{rst_n, reg_wr, reg_rd, op_valid, op_byte, reg_addr, op_code} = '0;
		{reg_wdata, op_offset, op_wdata, last_rd} = '0;
		{miscompares, total_checks, nref} = '0;
		pg = 8'h00;
		void'($urandom(25163));
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		shadow = pm.mem;
		rg(1'b0, pta_pkg::OFS_PAGE, 16'h0);
		chk(reg_rdata, {8'h0, pta_pkg::PAGE_RST});
		// Every code and mode at both ends of the window
		for (int i = 0; i < 16; i++)
			op(i[1:0], i[2], i[3] ? 16'h007f : 16'h0000, 16'(i * 4369));
		// Configuration space: writes refused, reads allowed
		setpg(8'h80);
		op(2'h2, 1'b0, 16'h0010, 16'hbeef);
		op(2'h3, 1'b1, 16'h0011, 16'h00aa);
		rg(1'b1, pta_pkg::OFS_STATUS, 16'h0);
		rg(1'b0, pta_pkg::OFS_STATUS, 16'h0);
		chk(reg_rdata, 16'(1 << pta_pkg::STAT_REFUSE_BIT));
		op(2'h0, 1'b0, 16'h0010, 16'h0);
		rg(1'b0, 4'hf, 16'h0);
		chk(reg_rdata, 16'h0);
		for (int i = 0; i < 40; i++)
		begin
			o = 16'($urandom % 128);
			setpg(($urandom % 4) == 0 ? 8'h80 : 8'h00);
			op(2'($urandom), 1'($urandom), o, 16'($urandom));
			op(2'h0, 1'b0, o, 16'h0);
			op(2'h1, 1'b0, o, 16'h0);
		end
		rg(1'b0, pta_pkg::OFS_REFUSED, 16'h0);
		chk(reg_rdata, 16'(nref));
		conclude();
	end
	// Watchdog against a hang
	initial
	begin
		repeat (6000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire

/* pta_write_merge.sv */
// Write data merge and byte enables for a 24-bit program word
`timescale 1ns/1ns
`default_nettype none
module pta_write_merge
(
	input wire logic [15:0] wdata,
	input wire logic high_op,
	input wire logic byte_mode,
	input wire logic byte_sel,
	output logic [23:0] wword,
	output logic [2:0] wbe
);
	// ----------------------------------------
	// Merge
	// ----------------------------------------
	// Byte enables mark program bytes 0,1,2; phantom byte writes nothing
	always_comb
	begin
		wword = 24'h000000;
		wbe = 3'h0;
		if (!high_op)
		begin
			if (!byte_mode)
			begin
				wword = {8'h00, wdata};
				wbe = 3'h3;
			end
			else if (byte_sel)
			begin
				wword = {8'h00, wdata[7:0], 8'h00};
				wbe = 3'h2;
			end
			else
			begin
				wword = {16'h0000, wdata[7:0]};
				wbe = 3'h1;
			end
		end
		else if (!(byte_mode && byte_sel))
		begin
			wword = {wdata[7:0], 16'h0000};
			wbe = 3'h4;
		end
	end
endmodule
`default_nettype wire
